/* design/acc_pkg.sv */
// Shared constants, register map and state type for the converter control block.
// Contract
// R1: The selected channel field drives the input connected to sample-and-hold.
// R2: After a channel change the controller waits a settling delay before converting; the code starts on the next go write with no such wait.
// R3: Reference select bit picks supply or external positive reference; negative is ground.
// R4: Clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC.
// R5: A 10-bit conversion takes eleven bit periods, one bit per period after first.
// R6: At conversion end both result registers load and the busy bit clears.
// R7: Holding capacitor is disconnected during conversion, reconnected afterwards.
// R8: Completion flag is set after every conversion, whatever the interrupt enable.
// R9: Completion flag stays set until software clears it.
// R10: Interrupt request is raised when completion flag and its enable are both set.
// R11: A converter interrupt during Sleep wakes the device.
// R12: After wake the next instruction runs; branch to handler only if globally enabled.
// R13: Result format bit selects left or right justification of the result pair.
// R14: Divided clocks follow the system clock; the RC option does not.
// R15: Software picks a clock setting meeting the minimum bit period.
// R16: Above 1 MHz, software uses the RC clock only for conversions in Sleep.
// R17: Software sets pin direction to input and analog select before converting.
// R18: The module enable bit powers the converter; writing busy bit one starts; the code starts only if the enable was set before that write.
// R19: Clearing the busy bit early leaves the previous result untouched.
// R20: After an abort, two bit periods pass before acquisition restarts automatically.
// R21: Left puts bits 9..0 at 15..6; right puts them at 9..0.
// R22: A start waits one conversion clock period before the first bit resolves.
`default_nettype none
package acc_pkg;
    localparam logic [4:0] OFF_CTRL0 = 5'h00;
    localparam logic [4:0] OFF_CTRL1 = 5'h04;
    localparam logic [4:0] OFF_FLAG = 5'h08;
    localparam logic [4:0] OFF_IRQEN = 5'h0C;
    localparam logic [4:0] OFF_RES_HI = 5'h10;
    localparam logic [4:0] OFF_RES_LO = 5'h14;

    localparam int CTRL0_ON = 0;
    localparam int CTRL0_GO = 1;
    localparam int CTRL0_CHS_LSB = 2;
    localparam int CHS_W = 4;
    localparam int CTRL0_REF = 6;
    localparam int CTRL0_JUST = 7;
    localparam int CTRL1_CS_LSB = 4;
    localparam int CS_W = 3;
    localparam int FLAG_DONE = 0;
    localparam int IRQEN_EN = 0;
    localparam int IRQEN_GIE = 1;

    localparam logic [CHS_W-1:0] CHS_RST = 4'h0;
    localparam logic [CS_W-1:0] CS_RST = 3'h0;
    localparam logic [1:0] CS_RC_CODE = 2'h3;

    localparam int RESULT_BITS = 10;
    localparam logic [3:0] CONV_TADS = 4'hB;
    localparam logic [3:0] ABORT_TADS = 4'h2;
    localparam logic [3:0] LAST_BIT_STEP = 4'h9;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_CONV = 2'b11,
        ST_ABORT = 2'b10
    } acc_state_t;
endpackage
`default_nettype wire

/* design/acc_tad_gen.sv */
// Bit-period tick generator: divided system clock or synchronised RC oscillator.
`default_nettype none
module acc_tad_gen (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] conv_clock_select,
    input wire logic rc_osc,
    output logic tad_tick
);
    logic [5:0] div_q, div_d;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic [5:0] div_last;
    logic use_rc;

    // Divide exponent 1..6 from the scrambled select code.
    function automatic logic [5:0] div_limit(input logic [2:0] sel);
        logic [2:0] e;
        e = {sel[1:0], 1'b0} + {2'b00, sel[2]} + 3'h1;
        div_limit = 6'((7'h01 << e) - 7'h01);
    endfunction

    assign use_rc = (conv_clock_select[1:0] == acc_pkg::CS_RC_CODE); // [R4]
    assign div_last = div_limit(conv_clock_select); // [R4]

    always_comb begin
        div_d = div_q;
        tad_tick = 1'b0;
        if (!run) begin
            div_d = 6'h00;
        end else if (use_rc) begin
            // The RC source is free of the system clock rate. [R14]
            tad_tick = rc_s2_q & ~rc_s3_q;
        end else if (div_q >= div_last) begin
            // Divided periods scale with whatever the system clock runs at. [R14]
            div_d = 6'h00;
            tad_tick = 1'b1;
        end else begin
            div_d = div_q + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_q <= 6'h00;
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            div_q <= div_d;
            rc_s1_q <= rc_osc;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end
endmodule
`default_nettype wire

/* design/acc_adc_ctrl.sv */
// Successive-approximation converter control with an Avalon-MM register slave.
//
// Register access over Avalon-MM and the address map were decided locally.
`default_nettype none
module acc_adc_ctrl #(
    parameter int RES_W = 10
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rc_osc,
    input wire logic comp_in,
    input wire logic cpu_sleep,
    output logic [3:0] channel_select,
    output logic pos_reference_select,
    output logic conv_module_on,
    output logic hold_connect,
    output logic [9:0] dac_code,
    output logic conv_irq,
    output logic wake_req,
    output logic isr_branch
);
    if (RES_W != acc_pkg::RESULT_BITS) begin : g_bad_width
        $error("Result width must be ten bits.");
    end
    if (acc_pkg::CHS_W != 4 || acc_pkg::CS_W != 3) begin : g_bad_fields
        $error("Channel and clock select fields must be four and three bits wide.");
    end
    if (acc_pkg::LAST_BIT_STEP != 4'(RES_W - 1)) begin : g_bad_steps
        $error("The last bit step must match the result width.");
    end

    localparam int CL = acc_pkg::CTRL0_CHS_LSB;
    localparam int SL = acc_pkg::CTRL1_CS_LSB;

    // Control and configuration registers.
    logic on_q, on_d;
    logic ref_q, ref_d;
    logic just_q, just_d;
    logic [3:0] chs_q, chs_d;
    logic [2:0] cs_q, cs_d;
    logic flag_q, flag_d;
    logic ie_q, ie_d;
    logic gie_q, gie_d;

    // Conversion engine.
    acc_pkg::acc_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [9:0] sar_q, sar_d;
    logic [9:0] res_q, res_d;
    logic hold_q, hold_d;
    logic cmp_s1_q, cmp_s2_q;

    // Bus answer.
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;

    logic tad_tick;
    logic wr_ctrl0, wr_ctrl1, wr_flag, wr_irqen;
    logic go_set, go_clr, done, busy;
    logic [3:0] bidx;
    logic [15:0] res_pair;

    // Places the result in the 16-bit pair by the justify bit.
    function automatic logic [15:0] place_result(input logic [9:0] r, input logic right);
        if (right) begin
            place_result = {6'h00, r}; // [R21]
        end else begin
            place_result = {r, 6'h00}; // [R21]
        end
    endfunction

    // Decodes a write strobe aimed at one register offset.
    function automatic logic write_hit(input logic wr, input logic [4:0] a,
        input logic [4:0] off);
        write_hit = wr && (a == off);
    endfunction

    // Bit under trial at a step count: step 0 tries the top bit.
    function automatic logic [3:0] bit_index(input logic [3:0] c);
        bit_index = acc_pkg::LAST_BIT_STEP - c;
    endfunction

    // True when the select code names the RC oscillator rather than a divider.
    function automatic logic uses_rc(input logic [2:0] sel);
        uses_rc = (sel[1:0] == acc_pkg::CS_RC_CODE);
    endfunction

    acc_tad_gen u_tad (
        .clock(clock),
        .rst_n(rst_n),
        .run(state_q != acc_pkg::ST_IDLE),
        .conv_clock_select(cs_q),
        .rc_osc(rc_osc),
        .tad_tick(tad_tick)
    );

    assign wr_ctrl0 = write_hit(avs_write, avs_address, acc_pkg::OFF_CTRL0);
    assign wr_ctrl1 = write_hit(avs_write, avs_address, acc_pkg::OFF_CTRL1);
    assign wr_flag = write_hit(avs_write, avs_address, acc_pkg::OFF_FLAG);
    assign wr_irqen = write_hit(avs_write, avs_address, acc_pkg::OFF_IRQEN);
    assign busy = (state_q == acc_pkg::ST_SYNC) || (state_q == acc_pkg::ST_CONV);
    // A start needs the module already powered before this write. [R18]
    assign go_set = wr_ctrl0 && avs_writedata[acc_pkg::CTRL0_GO] && on_q;
    assign go_clr = wr_ctrl0 && !avs_writedata[acc_pkg::CTRL0_GO];
    assign bidx = bit_index(cnt_q);
    assign done = (state_q == acc_pkg::ST_CONV) && tad_tick && (cnt_q == acc_pkg::LAST_BIT_STEP);
    assign res_pair = place_result(res_q, just_q); // [R13]

    // Register writes and the completion flag.
    always_comb begin
        on_d = on_q;
        ref_d = ref_q;
        just_d = just_q;
        chs_d = chs_q;
        cs_d = cs_q;
        ie_d = ie_q;
        gie_d = gie_q;
        flag_d = flag_q;
        if (wr_ctrl0) begin
            on_d = avs_writedata[acc_pkg::CTRL0_ON]; // [R18]
            ref_d = avs_writedata[acc_pkg::CTRL0_REF]; // [R3]
            just_d = avs_writedata[acc_pkg::CTRL0_JUST]; // [R13]
            chs_d = avs_writedata[CL+3:CL]; // [R1]
        end
        if (wr_ctrl1) begin
            cs_d = avs_writedata[SL+2:SL]; // [R4]
        end
        if (wr_irqen) begin
            ie_d = avs_writedata[acc_pkg::IRQEN_EN];
            gie_d = avs_writedata[acc_pkg::IRQEN_GIE];
        end
        // Only a written zero clears the flag, and a completion in the same cycle wins. [R9]
        if (wr_flag && !avs_writedata[acc_pkg::FLAG_DONE]) begin
            flag_d = 1'b0;
        end
        if (done) begin
            flag_d = 1'b1; // [R8]
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            on_q <= 1'b0;
            ref_q <= 1'b0;
            just_q <= 1'b0;
            chs_q <= acc_pkg::CHS_RST;
            cs_q <= acc_pkg::CS_RST;
            ie_q <= 1'b0;
            gie_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            on_q <= on_d;
            ref_q <= ref_d;
            just_q <= just_d;
            chs_q <= chs_d;
            cs_q <= cs_d;
            ie_q <= ie_d;
            gie_q <= gie_d;
            flag_q <= flag_d;
        end
    end

    // Conversion sequence: one sync period, ten bit periods, or a two-period abort wait.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sar_d = sar_q;
        res_d = res_q;
        unique case (state_q)
            acc_pkg::ST_IDLE: begin
                if (go_set) begin
                    state_d = acc_pkg::ST_SYNC; // [R18]
                    cnt_d = 4'h0;
                    sar_d = 10'h200;
                end
            end
            acc_pkg::ST_SYNC: begin
                // On a divided clock the divider restarted with the start, so this first period is a full one.
                if (tad_tick) begin
                    state_d = acc_pkg::ST_CONV; // [R22] [R5]
                end
            end
            acc_pkg::ST_CONV: begin
                if (tad_tick) begin
                    // Keep or drop the trial bit, then try the next lower one. [R5]
                    // The comparator arrives two clocks late, so the fastest divider sees stale trials.
                    sar_d[bidx] = cmp_s2_q;
                    if (bidx != 4'h0) begin
                        sar_d[bidx-4'h1] = 1'b1;
                    end
                    cnt_d = cnt_q + 4'h1;
                    if (done) begin
                        res_d = sar_d; // [R6]
                        state_d = acc_pkg::ST_IDLE; // [R6]
                    end
                end
            end
            acc_pkg::ST_ABORT: begin
                if (tad_tick) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == acc_pkg::ABORT_TADS - 4'h1) begin
                        state_d = acc_pkg::ST_IDLE; // [R20]
                    end
                end
            end
        endcase
        // Early clear, or Sleep on a divided clock, stops without touching the result. [R19]
        if (busy && !done && (go_clr || (cpu_sleep && !uses_rc(cs_q)))) begin
            state_d = acc_pkg::ST_ABORT;
            cnt_d = 4'h0;
        end
        if (!on_q) begin
            state_d = acc_pkg::ST_IDLE;
        end
        // Capacitor tracks the input only while idle and powered. [R7] [R20]
        hold_d = on_q && (state_d == acc_pkg::ST_IDLE);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= acc_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            sar_q <= 10'h000;
            res_q <= 10'h000;
            hold_q <= 1'b0;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sar_q <= sar_d;
            res_q <= res_d;
            hold_q <= hold_d;
            cmp_s1_q <= comp_in;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // Reads answer one cycle after the request; writes are taken at once.
    // A held read drops ack again after its answer, so reads cost two cycles each.
    always_comb begin
        ack_d = avs_read && !ack_q;
        rdata_d = rdata_q;
        if (avs_read && !ack_q) begin
            rdata_d = 32'h0000_0000;
            unique case (avs_address)
                acc_pkg::OFF_CTRL0: begin
                    rdata_d[7:0] = {just_q, ref_q, chs_q, busy, on_q}; // [R6]
                end
                acc_pkg::OFF_CTRL1: begin
                    rdata_d[SL+2:SL] = cs_q;
                end
                acc_pkg::OFF_FLAG: begin
                    rdata_d[acc_pkg::FLAG_DONE] = flag_q;
                end
                acc_pkg::OFF_IRQEN: begin
                    rdata_d[1:0] = {gie_q, ie_q};
                end
                acc_pkg::OFF_RES_HI: begin
                    rdata_d[7:0] = res_pair[15:8];
                end
                acc_pkg::OFF_RES_LO: begin
                    rdata_d[7:0] = res_pair[7:0];
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stands in rdata_q until the next read is taken.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = avs_read && !ack_q;
    assign avs_readdata = rdata_q;
    assign channel_select = chs_q; // [R1]
    assign pos_reference_select = ref_q; // [R3]
    assign conv_module_on = on_q; // [R18]
    assign hold_connect = hold_q; // [R7]
    assign dac_code = sar_q;
    // Interrupt and branch are levels from registers and stand while the flag does; wake also follows cpu_sleep.
    assign conv_irq = flag_q && ie_q; // [R10]
    assign wake_req = conv_irq && cpu_sleep; // [R11]
    // The core finishes the instruction after Sleep before it honours this. [R12]
    assign isr_branch = conv_irq && gie_q;
endmodule
`default_nettype wire

/* tb/acc_analog_model.sv */
// Analog channel and sample-and-hold model that drives the comparator.
`default_nettype none
module acc_analog_model (
    input wire logic clock,
    input wire logic [159:0] levels,
    input wire logic [3:0] channel_select,
    input wire logic hold_connect,
    input wire logic [9:0] dac_code,
    output logic comp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held = 10'h000;
    // The capacitor tracks the selected input only while connected.
    always @(posedge clock) begin
        if (hold_connect) begin
            held <= levels[channel_select * 10 +: 10];
        end
    end
    assign comp_in = held >= dac_code;
endmodule
`default_nettype wire

/* tb/acc_adc_ctrl_monitor.sv */
// Port checker for the converter control block and its bind.
`default_nettype none
module acc_adc_ctrl_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_sleep,
    input wire logic [3:0] channel_select,
    input wire logic pos_reference_select,
    input wire logic conv_module_on,
    input wire logic hold_connect,
    input wire logic [9:0] dac_code,
    input wire logic conv_irq,
    input wire logic wake_req,
    input wire logic isr_branch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [10:0] low_d, low_q;
    logic clr_d, clr_q;
    always_comb begin
        low_d = (hold_connect || !conv_module_on) ? 11'h000 : low_q + 11'h001;
        clr_d = avs_write && (avs_address == acc_pkg::OFF_FLAG
            || avs_address == acc_pkg::OFF_IRQEN);
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_q <= 11'h000;
            clr_q <= 1'b0;
        end else begin
            low_q <= low_d;
            clr_q <= clr_d;
        end
    end
    ctrl_write_a: assert property (avs_write && avs_address == acc_pkg::OFF_CTRL0 |=>
        conv_module_on == $past(avs_writedata[0]) && channel_select == $past(avs_writedata[5:2])
        && pos_reference_select == $past(avs_writedata[6])) else $error("control write lost");
    conv_start_a: assert property (avs_write && avs_address == acc_pkg::OFF_CTRL0
        && avs_writedata[1:0] == 2'h3 && conv_module_on && hold_connect
        |=> !hold_connect && dac_code == 10'h200) else $error("conversion did not start");
    conv_bound_a: assert property (low_q <= 11'h320) else $error("hold open too long");
    wake_gate_a: assert property (wake_req == (conv_irq && cpu_sleep))
        else $error("wake");
    isr_gate_a: assert property (isr_branch |-> conv_irq)
        else $error("branch without irq");
    flag_sticky_a: assert property ($fell(conv_irq) |-> clr_q)
        else $error("flag self cleared");
    flag_clear_a: assert property (avs_write && avs_address == acc_pkg::OFF_FLAG
        && !avs_writedata[0] && hold_connect |=> !conv_irq) else $error("flag not cleared");
    write_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("write wait");
    read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait state wrong");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address > acc_pkg::OFF_RES_LO |-> avs_readdata == 32'h0) else $error("unmapped");
    cover property ($fell(hold_connect));
    cover property (wake_req);
    cover property (isr_branch);
endmodule
bind acc_adc_ctrl acc_adc_ctrl_monitor i_acc_adc_ctrl_monitor (.clock, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_sleep,
    .channel_select, .pos_reference_select, .conv_module_on, .hold_connect, .dac_code,
    .conv_irq, .wake_req, .isr_branch);
`default_nettype wire

/* tb/acc_adc_ctrl_tb.sv */
// Self-checking bench for the converter control block.
`default_nettype none
module acc_adc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, comp_in, pos_reference_select, conv_module_on, hold_connect;
    logic rc_osc = 1'b0;
    logic cpu_sleep = 1'b0;
    logic conv_irq, wake_req, isr_branch;
    logic [3:0] channel_select;
    logic [9:0] dac_code;
    logic [159:0] levels;
    logic [31:0] seed = 32'h06E3153F;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;
    int exp_q[$];
    int tad_k[8] = '{1, 3, 5, 0, 2, 4, 6, 0};
    logic [2:0] codes[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    acc_adc_ctrl #(.RES_W(10)) i_acc_adc_ctrl (.clock, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rc_osc, .comp_in,
        .cpu_sleep, .channel_select, .pos_reference_select, .conv_module_on, .hold_connect,
        .dac_code, .conv_irq, .wake_req, .isr_branch);
    acc_analog_model i_acc_analog_model (.clock, .levels, .channel_select, .hold_connect,
        .dac_code, .comp_in);
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        rc_osc <= (cyc % 40) < 20;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] fmt(input int r, input logic j, input logic h);
        if (h) return j ? r >> 8 : r >> 2;
        return j ? r & 32'hFF : (r & 32'h3) << 6;
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Waits as long as the slave asks; only the bench timeout ends a hang.
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_hold(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hold_connect !== 1'b1 && n < 2000);
    endtask
    initial begin
        logic [31:0] q;
        logic [3:0] ch;
        logic [2:0] cs;
        logic just, rf, ien, gie, slp, ok;
        int n, t, res;
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            levels[i * 32 +: 32] = seed;
        end
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, acc_pkg::OFF_CTRL0, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, 5'h18, 32'h0, q);
        chk(q, 32'h0);
        $display("Test reset and unmapped read done");
        for (int i = 0; i < 8; i++) begin
            cs = codes[i];
            seed = lfsr(seed);
            {gie, ien, rf, just, ch} = seed[7:0];
            slp = cs[1:0] == 2'h3;
            t = 1 << tad_k[cs];
            ok = t >= 8 || slp;
            bus(1'b1, acc_pkg::OFF_CTRL1, {25'h0, cs, 4'h0}, q);
            bus(1'b1, acc_pkg::OFF_IRQEN, {30'h0, gie, ien}, q);
            bus(1'b1, acc_pkg::OFF_CTRL0, {24'h0, just, rf, ch, 2'h1}, q);
            cpu_sleep <= slp;
            repeat (4) @(posedge clock);
            bus(1'b1, acc_pkg::OFF_CTRL0, {24'h0, just, rf, ch, 2'h3}, q);
            wait_hold(n);
            chk(channel_select, ch);
            chk(pos_reference_select, rf);
            if (!slp) chk(n >= 11 * t && n <= 11 * t + 3, 32'h1);
            bus(1'b0, acc_pkg::OFF_CTRL0, 32'h0, q);
            chk(q[1], 32'h0);
            res = levels[ch * 10 +: 10];
            if (ok) exp_q.push_back(res);
            bus(1'b0, acc_pkg::OFF_RES_HI, 32'h0, q);
            if (ok) chk(q, fmt(res, just, 1'b1));
            bus(1'b0, acc_pkg::OFF_RES_LO, 32'h0, q);
            if (ok) chk(q, fmt(res, just, 1'b0));
            bus(1'b0, acc_pkg::OFF_FLAG, 32'h0, q);
            chk(q, 32'h1);
            chk(conv_irq, ien);
            chk(wake_req, ien & slp);
            chk(isr_branch, ien & gie);
            cpu_sleep <= 1'b0;
            bus(1'b1, acc_pkg::OFF_FLAG, 32'h1, q);
            bus(1'b0, acc_pkg::OFF_FLAG, 32'h0, q);
            chk(q, 32'h1);
            bus(1'b1, acc_pkg::OFF_FLAG, 32'h0, q);
            bus(1'b0, acc_pkg::OFF_FLAG, 32'h0, q);
            chk(q, 32'h0);
            chk(conv_irq, 32'h0);
            $display("Test conversion %0d with clock code %0d done", i, cs);
        end
        levels[ch * 10 +: 10] <= ~levels[ch * 10 +: 10];
        bus(1'b1, acc_pkg::OFF_CTRL1, 32'h50, q);
        bus(1'b1, acc_pkg::OFF_CTRL0, {24'h0, just, rf, ch, 2'h3}, q);
        repeat (40) @(posedge clock);
        bus(1'b1, acc_pkg::OFF_CTRL0, {24'h0, just, rf, ch, 2'h1}, q);
        wait_hold(n);
        chk(n <= 2 * 16 + 4, 32'h1);
        bus(1'b0, acc_pkg::OFF_RES_HI, 32'h0, q);
        chk(q, fmt(exp_q[$], just, 1'b1));
        bus(1'b0, acc_pkg::OFF_RES_LO, 32'h0, q);
        chk(q, fmt(exp_q[$], just, 1'b0));
        bus(1'b0, acc_pkg::OFF_FLAG, 32'h0, q);
        chk(q, 32'h0);
        $display("Test abort done");
        bus(1'b1, acc_pkg::OFF_CTRL0, {24'h0, just, rf, ch, 2'h3}, q);
        repeat (40) @(posedge clock);
        cpu_sleep <= 1'b1;
        wait_hold(n);
        cpu_sleep <= 1'b0;
        chk(n <= 2 * 16 + 4, 32'h1);
        bus(1'b0, acc_pkg::OFF_RES_LO, 32'h0, q);
        chk(q, fmt(exp_q[$], just, 1'b0));
        chk(conv_irq, 32'h0);
        $display("Test sleep abort done");
        bus(1'b1, acc_pkg::OFF_CTRL0, 32'h0, q);
        bus(1'b1, acc_pkg::OFF_CTRL0, 32'h3, q);
        repeat (4) @(posedge clock);
        chk(conv_module_on, 32'h1);
        chk(hold_connect, 32'h1);
        bus(1'b0, acc_pkg::OFF_CTRL0, 32'h0, q);
        chk(q[1], 32'h0);
        $display("Test power-on start refusal done");
        print_verdict();
    end
endmodule
`default_nettype wire
